/* inc/tcc_pkg.sv */
// Package for the timer capture/compare block: register map, bit fields, reset values, types.
// Assumes a 32-bit APB master in front and one 100 MHz clock for bus and counter alike.
package tcc_pkg;
   // Register byte offsets, one aligned word each.
   localparam logic [7:0] OFF_SC0 = 8'h00;
   localparam logic [7:0] OFF_SC1 = 8'h04;
   localparam logic [7:0] OFF_V0H = 8'h08;
   localparam logic [7:0] OFF_V0L = 8'h0C;
   localparam logic [7:0] OFF_V1H = 8'h10;
   localparam logic [7:0] OFF_V1L = 8'h14;
   localparam logic [7:0] OFF_CTL = 8'h18;
   localparam logic [7:0] OFF_MOD = 8'h1C;
   localparam logic [7:0] OFF_CNT = 8'h20;
   // Channel control/status bit positions.
   localparam int B_FLAG = 7;
   localparam int B_IE = 6;
   localparam int B_MSB = 5;
   localparam int B_MSA = 4;
   localparam int B_ELB = 3;
   localparam int B_ELA = 2;
   localparam int B_TOV = 1;
   localparam int B_MAX = 0;
   // Counter control bit positions.
   localparam int B_HALT = 0;
   localparam int B_CLR = 1;
   // Reset values.
   localparam logic [15:0] MOD_RST = 16'hFFFF;
   localparam logic HALT_RST = 1'b1;
   localparam int NCH = 2;

   // APB request as seen by the slave.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tcc_apb_s;

   // State of one channel.
   typedef struct packed {
      logic flag;
      logic ie;
      logic msb;
      logic msa;
      logic elb;
      logic ela;
      logic tov;
      logic max;
      logic arm;
      logic blk;
      logic inh;
      logic max_eff;
      logic pin;
      logic pin_prev;
      logic [15:0] val;
      logic [15:0] shadow;
   } tcc_chan_s;

   // Whole state of the block.
   typedef struct packed {
      tcc_chan_s [NCH-1:0] ch;
      logic halt;
      logic [15:0] cnt;
      logic [15:0] modv;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [NCH-1:0] irq;
      logic [NCH-1:0] pin_out;
      logic [NCH-1:0] pin_oe;
   } tcc_state_s;
endpackage : tcc_pkg

/* rtl/tcc_timer.sv */
// Two-channel 16-bit timer with input capture, output compare, PWM and APB registers.
// Assumes pins and bus are synchronous to i_clk; the pin pad merges out, oe and GPIO.
`timescale 1ns/1ps
// Behaviour
// RULE1: Capture mode sets the channel flag on the selected pin edge.
// RULE2: Compare mode sets the channel flag when counter equals channel value.
// RULE3: Flag clears by reading status with flag set, then writing zero.
// RULE4: An event between that read and the zero write voids the clear.
// RULE5: Writing one to the flag does nothing; reset clears the flag.
// RULE6: Interrupt request only while enable bit is one; reset clears enable.
// RULE7: Buffered select exists only on channel 0, enables buffered compare/PWM.
// RULE8: Channel 0 buffered mode disables channel 1 and frees its pin.
// RULE9: With edge field nonzero, select A picks capture (0) or compare (1).
// RULE10: With edge field 00, select A sets initial level: one low, zero high.
// RULE11: Software should halt and clear the counter before changing mode bits.
// RULE12: Edge field 00 disconnects the channel from its pin; reset clears it.
// RULE13: Capture edge: 01 rising, 10 falling, 11 either edge.
// RULE14: Compare pin action: 01 toggle, 10 clear, 11 set.
// RULE15: The pin should be stable two bus clocks before enabling capture.
// RULE16: Toggle-on-wrap toggles the pin on overflow, beating a same-time compare.
// RULE17: With toggle-on-wrap, full-duty force drives PWM at 100 percent duty.
// RULE18: Full-duty force changes take effect in the following PWM cycle.
// RULE19: Value registers hold capture value or compare value.
// RULE20: In capture mode, reading the high byte blocks captures until low read.
// RULE21: In compare mode, writing the high byte stops compares until low write.
// RULE22: Counter overflows at the modulo value and restarts at zero next tick.
// RULE23: Interrupt output is high while flag and enable are both one.
module tcc_timer (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset,
   // APB slave.
   input wire tcc_pkg::tcc_apb_s i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Channel pins and interrupt requests.
   input wire logic [tcc_pkg::NCH-1:0] i_pin,
   output logic [tcc_pkg::NCH-1:0] o_pin_out,
   output logic [tcc_pkg::NCH-1:0] o_pin_oe,
   output logic [tcc_pkg::NCH-1:0] o_irq
);
   tcc_pkg::tcc_state_s st_ff;
   tcc_pkg::tcc_state_s nxt_st;
   logic acc;
   logic wr;
   logic rd;
   logic ovf;
   logic tick;
   logic [tcc_pkg::NCH-1:0] cap_ev;
   logic [tcc_pkg::NCH-1:0] cmp_ev;
   logic [tcc_pkg::NCH-1:0] outc;
   logic [tcc_pkg::NCH-1:0] wr_sc;
   logic [tcc_pkg::NCH-1:0] rd_sc;

   // Next-state logic for bus, counter and both channels.
   always_comb begin
      logic [7:0] a_sc;
      logic [7:0] a_vh;
      logic [7:0] a_vl;
      logic buf_m;
      logic dis;
      logic cap;
      logic clr;
      logic [15:0] cmpv;
      logic [7:0] wd;
      a_sc = 8'h00;
      a_vh = 8'h00;
      a_vl = 8'h00;
      buf_m = 1'b0;
      dis = 1'b0;
      cap = 1'b0;
      clr = 1'b0;
      cmpv = 16'h0000;
      cap_ev = '0;
      cmp_ev = '0;
      outc = '0;
      wr_sc = '0;
      rd_sc = '0;
      nxt_st = st_ff;
      wd = i_apb.pwdata[7:0];
      // Two-cycle access: pready rises in the second access cycle, so decode stays registered.
      acc = i_apb.psel & i_apb.penable & st_ff.pready;
      wr = acc & i_apb.pwrite;
      rd = acc & ~i_apb.pwrite;
      nxt_st.pready = i_apb.psel & i_apb.penable & ~st_ff.pready;
      nxt_st.pslverr = 1'b0;
      // The counter advances every cycle unless halted.
      tick = ~st_ff.halt;
      ovf = tick & (st_ff.cnt == st_ff.modv);
      if (tick) begin
         nxt_st.cnt = ovf ? 16'h0000 : st_ff.cnt + 16'h0001; // see RULE22
      end
      for (int c = 0; c < tcc_pkg::NCH; c++) begin
         a_sc = (c == 0) ? tcc_pkg::OFF_SC0 : tcc_pkg::OFF_SC1;
         a_vh = (c == 0) ? tcc_pkg::OFF_V0H : tcc_pkg::OFF_V1H;
         a_vl = (c == 0) ? tcc_pkg::OFF_V0L : tcc_pkg::OFF_V1L;
         buf_m = (c == 0) & st_ff.ch[0].msb; // see RULE7
         dis = (c == 1) & st_ff.ch[0].msb; // see RULE8
         // Mode decode from select bits and edge field.
         cap = (st_ff.ch[c].elb | st_ff.ch[c].ela) & ~st_ff.ch[c].msa & ~buf_m & ~dis; // see RULE9
         outc[c] = (st_ff.ch[c].elb | st_ff.ch[c].ela) & (st_ff.ch[c].msa | buf_m) & ~dis;
         // Capture on the selected edge unless a high-byte read is pending.
         cap_ev[c] = cap & ~st_ff.ch[c].blk &
            ((st_ff.ch[c].ela & i_pin[c] & ~st_ff.ch[c].pin_prev) |
             (st_ff.ch[c].elb & ~i_pin[c] & st_ff.ch[c].pin_prev)); // see RULE13
         // Buffered mode compares against a copy refreshed only at overflow.
         cmpv = buf_m ? st_ff.ch[c].shadow : st_ff.ch[c].val;
         cmp_ev[c] = outc[c] & tick & ~st_ff.ch[c].inh & (st_ff.cnt == cmpv); // see RULE2, RULE21
         nxt_st.ch[c].pin_prev = i_pin[c];
         if (cap_ev[c]) begin
            nxt_st.ch[c].val = st_ff.cnt; // see RULE19
         end
         if (ovf | ~buf_m) begin
            nxt_st.ch[c].shadow = st_ff.ch[c].val;
         end
         // Full duty is latched at the period boundary so a change never cuts a pulse.
         if (ovf) begin
            nxt_st.ch[c].max_eff = st_ff.ch[c].tov & st_ff.ch[c].max; // see RULE18
         end
         // Pin level: preset when disconnected, else full duty first, then overflow, then compare.
         if (~(st_ff.ch[c].elb | st_ff.ch[c].ela)) begin
            nxt_st.ch[c].pin = ~st_ff.ch[c].msa; // see RULE10
         end else if (outc[c]) begin
            if (st_ff.ch[c].max_eff) begin
               nxt_st.ch[c].pin = 1'b1; // see RULE17
            end else if (st_ff.ch[c].tov & ovf) begin
               nxt_st.ch[c].pin = ~st_ff.ch[c].pin; // see RULE16
            end else if (cmp_ev[c]) begin
               case ({st_ff.ch[c].elb, st_ff.ch[c].ela}) // see RULE14
                  2'b01: nxt_st.ch[c].pin = ~st_ff.ch[c].pin;
                  2'b10: nxt_st.ch[c].pin = 1'b0;
                  2'b11: nxt_st.ch[c].pin = 1'b1;
                  default: nxt_st.ch[c].pin = st_ff.ch[c].pin;
               endcase
            end
         end
         // Status register access; a disabled channel 1 ignores writes.
         wr_sc[c] = wr & (i_apb.paddr == a_sc) & ~dis;
         rd_sc[c] = rd & (i_apb.paddr == a_sc);
         clr = wr_sc[c] & ~wd[tcc_pkg::B_FLAG] & st_ff.ch[c].arm; // see RULE3, RULE5
         if (rd_sc[c] & st_ff.ch[c].flag) begin
            nxt_st.ch[c].arm = 1'b1;
         end
         if (wr_sc[c]) begin
            nxt_st.ch[c].arm = 1'b0;
            nxt_st.ch[c].ie = wd[tcc_pkg::B_IE];
            nxt_st.ch[c].msb = (c == 0) & wd[tcc_pkg::B_MSB]; // see RULE7
            nxt_st.ch[c].msa = wd[tcc_pkg::B_MSA];
            nxt_st.ch[c].elb = wd[tcc_pkg::B_ELB];
            nxt_st.ch[c].ela = wd[tcc_pkg::B_ELA];
            nxt_st.ch[c].tov = wd[tcc_pkg::B_TOV];
            nxt_st.ch[c].max = wd[tcc_pkg::B_MAX];
         end
         // A new event disarms a pending clear; the set always wins.
         if (cap_ev[c] | cmp_ev[c]) begin
            nxt_st.ch[c].arm = 1'b0; // see RULE4
         end
         nxt_st.ch[c].flag = (st_ff.ch[c].flag & ~clr) | cap_ev[c] | cmp_ev[c]; // see RULE1
         // Byte access to the value registers.
         if (wr & (i_apb.paddr == a_vh)) begin
            nxt_st.ch[c].val[15:8] = wd;
            nxt_st.ch[c].inh = st_ff.ch[c].msb | st_ff.ch[c].msa; // see RULE21
         end
         if (wr & (i_apb.paddr == a_vl)) begin
            nxt_st.ch[c].val[7:0] = wd;
            nxt_st.ch[c].inh = 1'b0;
         end
         if (rd & (i_apb.paddr == a_vh) & ~st_ff.ch[c].msb & ~st_ff.ch[c].msa) begin
            nxt_st.ch[c].blk = 1'b1; // see RULE20
         end
         if (rd & (i_apb.paddr == a_vl)) begin
            nxt_st.ch[c].blk = 1'b0;
         end
         nxt_st.irq[c] = nxt_st.ch[c].flag & nxt_st.ch[c].ie; // see RULE6, RULE23
         // Disconnected or capture channels leave the pin to the port.
         nxt_st.pin_oe[c] = (nxt_st.ch[c].elb | nxt_st.ch[c].ela) &
            (nxt_st.ch[c].msa | ((c == 0) & nxt_st.ch[0].msb)) &
            ~((c == 1) & nxt_st.ch[0].msb); // see RULE12, RULE8
         nxt_st.pin_out[c] = nxt_st.ch[c].pin;
      end
      // Counter control: the clear bit is self-clearing and never reads back.
      if (wr & (i_apb.paddr == tcc_pkg::OFF_CTL)) begin
         nxt_st.halt = i_apb.pwdata[tcc_pkg::B_HALT];
         if (i_apb.pwdata[tcc_pkg::B_CLR]) begin
            nxt_st.cnt = 16'h0000;
         end
      end
      if (wr & (i_apb.paddr == tcc_pkg::OFF_MOD)) begin
         nxt_st.modv = i_apb.pwdata[15:0];
      end
      // Read data is registered with pready; unmapped addresses answer with pslverr.
      nxt_st.prdata = 32'h0000_0000;
      if (i_apb.psel & i_apb.penable & ~st_ff.pready & ~i_apb.pwrite) begin
         case (i_apb.paddr)
            tcc_pkg::OFF_SC0: nxt_st.prdata[7:0] = {st_ff.ch[0].flag, st_ff.ch[0].ie,
               st_ff.ch[0].msb, st_ff.ch[0].msa, st_ff.ch[0].elb, st_ff.ch[0].ela,
               st_ff.ch[0].tov, st_ff.ch[0].max};
            tcc_pkg::OFF_SC1: nxt_st.prdata[7:0] = st_ff.ch[0].msb ? 8'h00 :
               {st_ff.ch[1].flag, st_ff.ch[1].ie, 1'b0, st_ff.ch[1].msa,
               st_ff.ch[1].elb, st_ff.ch[1].ela, st_ff.ch[1].tov, st_ff.ch[1].max};
            tcc_pkg::OFF_V0H: nxt_st.prdata[7:0] = st_ff.ch[0].val[15:8];
            tcc_pkg::OFF_V0L: nxt_st.prdata[7:0] = st_ff.ch[0].val[7:0];
            tcc_pkg::OFF_V1H: nxt_st.prdata[7:0] = st_ff.ch[1].val[15:8];
            tcc_pkg::OFF_V1L: nxt_st.prdata[7:0] = st_ff.ch[1].val[7:0];
            tcc_pkg::OFF_CTL: nxt_st.prdata[0] = st_ff.halt;
            tcc_pkg::OFF_MOD: nxt_st.prdata[15:0] = st_ff.modv;
            tcc_pkg::OFF_CNT: nxt_st.prdata[15:0] = st_ff.cnt;
            default: nxt_st.pslverr = 1'b1;
         endcase
      end
      if (i_apb.psel & i_apb.penable & ~st_ff.pready & i_apb.pwrite) begin
         nxt_st.pslverr = (i_apb.paddr > tcc_pkg::OFF_MOD) | (i_apb.paddr[1:0] != 2'b00);
      end
   end

   // State register; value words are cleared too, though software must not rely on it.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_ff <= '0;
         st_ff.halt <= tcc_pkg::HALT_RST;
         st_ff.modv <= tcc_pkg::MOD_RST;
         for (int c = 0; c < tcc_pkg::NCH; c++) begin
            st_ff.ch[c].pin <= 1'b1;
         end
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs come straight from the state register.
   assign o_prdata = st_ff.prdata;
   assign o_pready = st_ff.pready;
   assign o_pslverr = st_ff.pslverr;
   assign o_pin_out = st_ff.pin_out;
   assign o_pin_oe = st_ff.pin_oe;
   assign o_irq = st_ff.irq;

   // Checks on channel 0 behaviour and the counter.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_armed_read;
      rd_sc[0] && st_ff.ch[0].flag;
   endsequence

   sequence s_zero_write;
      wr_sc[0] && !i_apb.pwdata[tcc_pkg::B_FLAG] && !cap_ev[0] && !cmp_ev[0];
   endsequence

   a_capture_sets_flag: assert property (cap_ev[0] |=> st_ff.ch[0].flag) // see RULE1
      else $error("capture did not set flag");
   a_compare_sets_flag: assert property (cmp_ev[0] |=> st_ff.ch[0].flag) // see RULE2
      else $error("compare did not set flag");
   // The zero write completes four cycles after the arming read when issued back to back.
   a_two_step_clear: assert property (s_armed_read ##4 s_zero_write |=> !st_ff.ch[0].flag)
      else $error("read then zero write did not clear flag"); // see RULE3
   a_clear_needs_read: assert property ($fell(st_ff.ch[0].flag) |-> $past(st_ff.ch[0].arm))
      else $error("flag cleared without prior read"); // see RULE3
   a_event_beats_clear: assert property ((cap_ev[0] || cmp_ev[0]) |=> st_ff.ch[0].flag)
      else $error("event lost to clear"); // see RULE4
   a_one_write_noop: assert property (wr_sc[0] && i_apb.pwdata[tcc_pkg::B_FLAG] &&
      !st_ff.ch[0].flag && !cap_ev[0] && !cmp_ev[0] |=> !st_ff.ch[0].flag) // see RULE5
      else $error("writing one set the flag");
   a_irq_gate: assert property (o_irq[0] == (st_ff.ch[0].flag && st_ff.ch[0].ie))
      else $error("irq does not follow flag and enable"); // see RULE6, RULE23
   a_ch1_freed: assert property (st_ff.ch[0].msb |-> !o_pin_oe[1] && !cap_ev[1])
      else $error("channel 1 active in buffered mode"); // see RULE8
   a_gpio_release: assert property (!st_ff.ch[0].elb && !st_ff.ch[0].ela |-> !o_pin_oe[0])
      else $error("disconnected channel drives pin"); // see RULE12
   a_wrap_restart: assert property (ovf |=> st_ff.cnt == 16'h0000)
      else $error("counter did not restart after overflow"); // see RULE22
   a_wrap_toggle: assert property (outc[0] && st_ff.ch[0].tov && ovf && !st_ff.ch[0].max_eff
      |=> st_ff.ch[0].pin != $past(st_ff.ch[0].pin)) // see RULE16
      else $error("pin did not toggle on overflow");
   a_duty_latency: assert property ($changed(st_ff.ch[0].max_eff) |-> $past(ovf))
      else $error("full duty changed inside a period"); // see RULE18
   a_full_duty: assert property (st_ff.ch[0].max_eff && outc[0] |=> st_ff.ch[0].pin)
      else $error("full duty not held high"); // see RULE17
   a_capture_block: assert property (st_ff.ch[0].blk |-> !cap_ev[0])
      else $error("capture while high byte read pending"); // see RULE20

   // Compare actions that neither full duty nor a wrap toggle overrides.
   sequence s_set_cmp;
      cmp_ev[0] && !st_ff.ch[0].max_eff && !(st_ff.ch[0].tov && ovf) &&
         st_ff.ch[0].elb && st_ff.ch[0].ela;
   endsequence

   sequence s_clr_cmp;
      cmp_ev[0] && !st_ff.ch[0].max_eff && !(st_ff.ch[0].tov && ovf) &&
         st_ff.ch[0].elb && !st_ff.ch[0].ela;
   endsequence

   a_set_action: assert property (s_set_cmp |=> st_ff.ch[0].pin)
      else $error("set action did not raise pin"); // see RULE14
   a_clear_action: assert property (s_clr_cmp |=> !st_ff.ch[0].pin)
      else $error("clear action did not lower pin"); // see RULE14
   a_preset_level: assert property (!st_ff.ch[0].elb && !st_ff.ch[0].ela
      |=> st_ff.ch[0].pin == !$past(st_ff.ch[0].msa)) // see RULE10
      else $error("preset level does not follow select A");
   a_capture_mode: assert property (cap_ev[0] |-> !outc[0])
      else $error("capture while in compare mode"); // see RULE9
   a_rise_only: assert property (cap_ev[0] && !st_ff.ch[0].elb |-> i_pin[0])
      else $error("rising-only capture on a falling pin"); // see RULE13
   a_fall_only: assert property (cap_ev[0] && !st_ff.ch[0].ela |-> !i_pin[0])
      else $error("falling-only capture on a rising pin"); // see RULE13
   a_capture_value: assert property (cap_ev[0] && !wr |=> st_ff.ch[0].val == $past(st_ff.cnt))
      else $error("captured value is not the counter"); // see RULE19
   a_compare_inhibit: assert property (st_ff.ch[0].inh |-> !cmp_ev[0])
      else $error("compare while high byte write pending"); // see RULE21
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

   // Channel 1 keeps the same flag, interrupt and pin rules as channel 0.
   a_ch1_capture_flag: assert property (cap_ev[1] |=> st_ff.ch[1].flag)
      else $error("channel 1 capture did not set flag"); // see RULE1
   a_ch1_compare_flag: assert property (cmp_ev[1] |=> st_ff.ch[1].flag)
      else $error("channel 1 compare did not set flag"); // see RULE2
   a_ch1_irq_gate: assert property (o_irq[1] == (st_ff.ch[1].flag && st_ff.ch[1].ie))
      else $error("channel 1 irq does not follow flag and enable"); // see RULE6
   a_ch1_no_buffer: assert property (!st_ff.ch[1].msb)
      else $error("buffered select set on channel 1"); // see RULE7
   a_ch1_release: assert property (!st_ff.ch[1].elb && !st_ff.ch[1].ela |-> !o_pin_oe[1])
      else $error("disconnected channel 1 drives pin"); // see RULE12
   a_ch1_block: assert property (st_ff.ch[1].blk |-> !cap_ev[1])
      else $error("channel 1 capture while blocked"); // see RULE20
   a_ch1_inhibit: assert property (st_ff.ch[1].inh |-> !cmp_ev[1])
      else $error("channel 1 compare while inhibited"); // see RULE21
   a_ch1_rise_only: assert property (cap_ev[1] && !st_ff.ch[1].elb |-> i_pin[1])
      else $error("channel 1 rising-only capture on a falling pin"); // see RULE13
   a_ch1_fall_only: assert property (cap_ev[1] && !st_ff.ch[1].ela |-> !i_pin[1])
      else $error("channel 1 falling-only capture on a rising pin"); // see RULE13
endmodule : tcc_timer

/* testbench/tcc_pin_model.sv */
// Far-side model of the two channel pins: one outside signal source per pin.
// Assumes the bench moves each source just after a rising clock edge.
`timescale 1ns/1ps
module tcc_pin_model (
   // Block side of each pin.
   input wire logic [tcc_pkg::NCH-1:0] i_pin_out,
   input wire logic [tcc_pkg::NCH-1:0] i_pin_oe,
   // Outside source levels and the resolved wire.
   input wire logic [tcc_pkg::NCH-1:0] i_src,
   output logic [tcc_pkg::NCH-1:0] o_pin
);
   // The block owns the wire while it drives, otherwise the source is seen.
   // The bench holds a source for three clocks before any capture is armed.
   assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_src);
endmodule : tcc_pin_model

/* testbench/tcc_timer_tb.sv */
// Self-checking bench for the timer channels, driven through APB register calls.
// Assumes the design package is compiled first and one 100 MHz clock.
`timescale 1ns/1ps
module tcc_timer_tb;
   // Clock, reset and the block's ports.
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   tcc_pkg::tcc_apb_s i_apb = '0;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   logic [1:0] pin;
   logic [1:0] o_pin_out;
   logic [1:0] o_pin_oe;
   logic [1:0] o_irq;
   logic [1:0] src = 2'h0;
   int errors = 0;
   int check_count = 0;
   logic [31:0] r;
   logic e;
   logic [7:0] cfg;
   logic f;
   logic [1:0] acts [3] = '{2'h2, 2'h3, 2'h1};
   logic pexp [3] = '{1'b0, 1'b1, 1'b0};

   // The clock toggles every half period.
   always #5 i_clk = ~i_clk;

   tcc_timer u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_apb(i_apb), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin(pin), .o_pin_out(o_pin_out),
      .o_pin_oe(o_pin_oe), .o_irq(o_irq));
   tcc_pin_model u_pin (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_src(src), .o_pin(pin));

   task automatic end_of_test();
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; the wait for pready is bounded so a hang ends the run.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rdat, output logic err);
      int n;
      i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge i_clk);
      i_apb.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         end_of_test();
      end
      rdat = o_prdata;
      err = o_pslverr;
      i_apb <= '0;
      @(posedge i_clk);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, '0, r, e);
      chk(r, x);
   endtask : rd

   // Read with the flag set arms the clear, the write then clears it.
   task automatic clr(input logic [7:0] a, input logic [7:0] v);
      xfer(1'b0, a, '0, r, e);
      wr(a, {24'h0, v});
   endtask : clr

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc

   task automatic flip();
      src[0] <= ~src[0];
      cyc(3);
   endtask : flip

   // Main sequence: reset state, compare, capture, flag handshake, modes.
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      chk({o_irq, o_pin_oe}, 0);
      rd(tcc_pkg::OFF_SC0, 0);
      rd(tcc_pkg::OFF_SC1, 0);
      rd(tcc_pkg::OFF_CTL, 1);
      rd(tcc_pkg::OFF_MOD, 32'h0000FFFF);
      xfer(1'b0, 8'h24, '0, r, e);
      chk({r, e}, 1);
      xfer(1'b1, tcc_pkg::OFF_CNT, 32'h5, r, e);
      chk(e, 1);
      // Each compare action, counter halted and cleared before every mode change.
      for (int k = 0; k < 3; k++) begin
         cfg = 8'h50 | {4'h0, acts[k], 2'h0};
         wr(tcc_pkg::OFF_CTL, 3);
         wr(tcc_pkg::OFF_V0H, 0);
         wr(tcc_pkg::OFF_V0L, 32'h10);
         clr(tcc_pkg::OFF_SC0, cfg);
         wr(tcc_pkg::OFF_CTL, 0);
         cyc(40);
         rd(tcc_pkg::OFF_SC0, {24'h0, cfg | 8'h80});
         chk(o_pin_out[0], pexp[k]);
         chk({o_pin_oe[0], o_irq[0]}, 3);
      end
      // A lone high-byte write suppresses compares until the low byte lands.
      wr(tcc_pkg::OFF_CTL, 3);
      clr(tcc_pkg::OFF_SC0, 8'h5C);
      wr(tcc_pkg::OFF_V0H, 0);
      wr(tcc_pkg::OFF_CTL, 0);
      cyc(40);
      rd(tcc_pkg::OFF_SC0, 32'h5C);
      wr(tcc_pkg::OFF_CTL, 3);
      wr(tcc_pkg::OFF_V0L, 32'h10);
      wr(tcc_pkg::OFF_CTL, 0);
      cyc(40);
      rd(tcc_pkg::OFF_SC0, 32'hDC);
      rd(tcc_pkg::OFF_V0L, 32'h10);
      // Capture edges; the mode is set first so the pin hand-over edge is cleared before the tested ones.
      wr(tcc_pkg::OFF_CTL, 3);
      clr(tcc_pkg::OFF_SC0, 8'h4C);
      cyc(3);
      for (int el = 1; el < 4; el++) begin
         for (int s = 0; s < 2; s++) begin
            cfg = 8'h40 | 8'(el << 2);
            src[0] <= s[0];
            cyc(3);
            clr(tcc_pkg::OFF_SC0, cfg);
            flip();
            f = (el == 3) || (el == 1 && s == 0) || (el == 2 && s == 1);
            rd(tcc_pkg::OFF_SC0, {24'h0, f, cfg[6:0]});
            chk(o_irq[0], f);
         end
      end
      // An event between the arming read and the zero write keeps the flag.
      clr(tcc_pkg::OFF_SC0, 8'h4C);
      flip();
      rd(tcc_pkg::OFF_SC0, 32'hCC);
      flip();
      wr(tcc_pkg::OFF_SC0, 32'h4C);
      rd(tcc_pkg::OFF_SC0, 32'hCC);
      wr(tcc_pkg::OFF_SC0, 32'h4C);
      rd(tcc_pkg::OFF_SC0, 32'h4C);
      wr(tcc_pkg::OFF_SC0, 32'hCC);
      rd(tcc_pkg::OFF_SC0, 32'h4C);
      // Reading the high byte blocks captures until the low byte is read.
      xfer(1'b0, tcc_pkg::OFF_V0H, '0, r, e);
      flip();
      rd(tcc_pkg::OFF_SC0, 32'h4C);
      xfer(1'b0, tcc_pkg::OFF_V0L, '0, r, e);
      flip();
      rd(tcc_pkg::OFF_SC0, 32'hCC);
      // With the enable off a set flag requests nothing.
      clr(tcc_pkg::OFF_SC0, 8'h0C);
      flip();
      rd(tcc_pkg::OFF_SC0, 32'h8C);
      chk(o_irq[0], 0);
      // Buffered select lives on channel 0 only and takes channel 1 off its pin.
      wr(tcc_pkg::OFF_SC1, 32'h7C);
      rd(tcc_pkg::OFF_SC1, 32'h5C);
      chk(o_pin_oe[1], 1);
      wr(tcc_pkg::OFF_SC0, 32'h2C);
      rd(tcc_pkg::OFF_SC0, 32'h2C);
      rd(tcc_pkg::OFF_SC1, 0);
      chk(o_pin_oe[1], 0);
      wr(tcc_pkg::OFF_SC0, 32'h10);
      rd(tcc_pkg::OFF_SC0, 32'h10);
      chk(o_pin_oe[0], 0);
      // Toggle on wrap with a short modulo, then full duty from the next period.
      wr(tcc_pkg::OFF_CTL, 3);
      wr(tcc_pkg::OFF_MOD, 7);
      wr(tcc_pkg::OFF_V0H, 0);
      wr(tcc_pkg::OFF_V0L, 32'h10);
      wr(tcc_pkg::OFF_SC0, 32'h56);
      wr(tcc_pkg::OFF_CTL, 0);
      cyc(5);
      f = o_pin_out[0];
      cyc(8);
      chk(o_pin_out[0], !f);
      wr(tcc_pkg::OFF_SC0, 32'h57);
      cyc(10);
      chk(o_pin_out[0], 1);
      cyc(4);
      chk(o_pin_out[0], 1);
      end_of_test();
   end
endmodule : tcc_timer_tb
